// ===== monitor_cfg_pkg.sv
package monitor_cfg_pkg;

	// Register indices; byte address is four times the index
	localparam logic [5:0] IDX_CONV_CHANNEL_CONTROL = 6'h16;
	localparam logic [5:0] IDX_ATTEN_CONFIG_A = 6'h18;
	localparam logic [5:0] IDX_ATTEN_CONFIG_B = 6'h19;
	localparam logic [5:0] IDX_FAN_RAMP_CONTROL_A = 6'h1A;
	localparam logic [5:0] IDX_BLOCK_STATUS = 6'h1E;
	localparam logic [5:0] IDX_BLOCK_CONTROL = 6'h1F;

	// Reset values
	localparam logic [7:0] RST_CONV_CHANNEL_CONTROL = 8'h00;
	localparam logic [7:0] RST_ATTEN_CONFIG_A = 8'hFF;
	localparam logic [7:0] RST_ATTEN_CONFIG_B = 8'h37;
	localparam logic [7:0] RST_FAN_RAMP_CONTROL_A = 8'h00;

	// Channel control fields
	localparam int EXTRA_OUT_A_BIT = 0;
	localparam int EXTRA_OUT_B_BIT = 1;
	localparam int SINGLE_MODE_BIT = 2;
	localparam int CHAN_SEL_LSB = 3;
	localparam int CHAN_SEL_MSB = 7;
	// Highest channel code that maps to a real input
	localparam logic [4:0] CHAN_CODE_LAST = 5'h11;

	// Attenuator fields
	localparam int ATTEN_A_RSVD_BIT = 0;
	localparam logic [7:0] ATTEN_B_RSVD_MASK = 8'hC8;

	// Acoustics fields
	localparam int ACOUSTIC_A_BIT = 0;
	localparam int ACOUSTIC_B_BIT = 1;
	localparam int RATE_A_LSB = 2;
	localparam int RATE_B_LSB = 5;
	localparam int RATE_WIDTH = 3;

	// Block control fields
	localparam int SOFT_RESET_BIT = 0;
	localparam int LOCK_BIT = 1;
	localparam int STATUS_LOCK_BIT = 16;

	// Ramp timing: slowest code walks 33 % to 100 % duty in 35 s
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned RAMP_SLOWEST_TIME_S = 35;
	localparam int unsigned RAMP_SPAN_STEPS = 170;
	localparam int unsigned SLOT_CYCLES = RAMP_SLOWEST_TIME_S * CLK_HZ / RAMP_SPAN_STEPS;
	localparam int SLOT_CNT_WIDTH = 24;

	typedef enum logic [1:0] {
		RAMP_HOLD = 2'b00,
		RAMP_UP = 2'b01,
		RAMP_DOWN = 2'b10
	} ramp_dir_t;

	function automatic logic [7:0] ramp_step(input logic [2:0] code);
		logic [7:0] step;
		step = 8'h01;
		case (code)
			3'h0: step = 8'h01;
			3'h1: step = 8'h02;
			3'h2: step = 8'h03;
			3'h3: step = 8'h05;
			3'h4: step = 8'h08;
			3'h5: step = 8'h0C;
			3'h6: step = 8'h18;
			3'h7: step = 8'h30;
			default: step = 8'h01;
		endcase
		return step;
	endfunction

endpackage

// ===== fan_duty_ramp.sv
module fan_duty_ramp #(
	parameter int unsigned SLOT_CYCLES = monitor_cfg_pkg::SLOT_CYCLES
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic ce_in,
	// Configuration
	input wire logic enable_in,
	input wire logic [2:0] rate_in,
	input wire logic [7:0] target_duty_in,
	// Applied duty
	output logic [7:0] duty_out
);

	logic [monitor_cfg_pkg::SLOT_CNT_WIDTH-1:0] slot_cnt;
	logic slot_tick;
	logic [7:0] step;
	monitor_cfg_pkg::ramp_dir_t dir;

	assign slot_tick = (slot_cnt == monitor_cfg_pkg::SLOT_CNT_WIDTH'(SLOT_CYCLES - 1));
	assign step = monitor_cfg_pkg::ramp_step(rate_in);

	always_comb begin
		if (target_duty_in > duty_out) begin
			dir = monitor_cfg_pkg::RAMP_UP;
		end else if (target_duty_in < duty_out) begin
			dir = monitor_cfg_pkg::RAMP_DOWN;
		end else begin
			dir = monitor_cfg_pkg::RAMP_HOLD;
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			slot_cnt <= '0;
		end else if (ce_in) begin
			slot_cnt <= slot_tick ? '0 : slot_cnt + 1'b1;
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			duty_out <= 8'h00;
		end else if (ce_in) begin
			if (!enable_in) begin
				duty_out <= target_duty_in;
			end else if (slot_tick) begin
				case (dir)
					monitor_cfg_pkg::RAMP_UP: begin
						duty_out <= (target_duty_in - duty_out > step) ? duty_out + step
							: target_duty_in;
					end
					monitor_cfg_pkg::RAMP_DOWN: begin
						duty_out <= (duty_out - target_duty_in > step) ? duty_out - step
							: target_duty_in;
					end
					default: duty_out <= duty_out;
				endcase
			end
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);

	AST_RAMP_STEP_BOUND: assert property (
		(ce_in && enable_in && $past(ce_in) && $past(enable_in)) |->
		((duty_out >= $past(duty_out) ? duty_out - $past(duty_out)
			: $past(duty_out) - duty_out) <= $past(step)))
		else $error("Applied duty moved more than one step");

	AST_RAMP_DIRECT_FOLLOW: assert property (
		(ce_in && !enable_in) |=> (duty_out == $past(target_duty_in)))
		else $error("Applied duty did not follow target with ramp off");

endmodule // fan_duty_ramp

// ===== monitor_config_registers.sv
// Our own choice: the APB interface to the registers.
module monitor_config_registers #(
	parameter int unsigned SLOT_CYCLES = monitor_cfg_pkg::SLOT_CYCLES
) (
	// Clock, reset, enable
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic ce_in,
	// APB slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// Fan duty targets from the speed controller
	input wire logic [7:0] fan_drive_one_target_in,
	input wire logic [7:0] fan_drive_two_target_in,
	// Extra output function on general pins
	output logic extra_output_enable_a_out,
	output logic extra_output_enable_b_out,
	// Measurement sequencer
	output logic single_channel_mode_out,
	output logic [4:0] channel_select_out,
	output logic single_channel_active_out,
	// Analog input conditioning
	output logic [7:0] attenuator_cfg_a_out,
	output logic [7:0] attenuator_cfg_b_out,
	// Fan ramp and configuration lock status
	output logic acoustic_enable_a_out,
	output logic acoustic_enable_b_out,
	output logic [7:0] fan_drive_one_duty_out,
	output logic [7:0] fan_drive_two_duty_out,
	output logic config_locked_out
);

	logic [7:0] conv_ctrl;
	logic [7:1] atten_a;
	logic [7:0] atten_b;
	logic [7:0] ramp_ctrl;
	logic lock;
	logic [31:0] next_rdata;
	logic next_slverr;
	logic access_done;
	logic wr_done;
	logic addr_aligned;
	logic [5:0] idx;
	logic cfg_wr;
	logic soft_reset;
	logic [1:0] ramp_enable;
	logic [1:0][2:0] ramp_rate;
	logic [1:0][7:0] ramp_target;
	logic [1:0][7:0] ramp_duty;

	assign idx = paddr_in[7:2];
	assign addr_aligned = (paddr_in[1:0] == 2'b00);
	assign access_done = ce_in && psel_in && penable_in && pready_out;
	assign wr_done = access_done && pwrite_in && addr_aligned;
	assign cfg_wr = wr_done && !lock;
	assign soft_reset = wr_done && (idx == monitor_cfg_pkg::IDX_BLOCK_CONTROL)
		&& pwdata_in[monitor_cfg_pkg::SOFT_RESET_BIT];

	// One wait state: pready rises in the second access cycle
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			pready_out <= 1'b0;
		end else if (ce_in) begin
			pready_out <= psel_in && penable_in && !pready_out;
		end
	end

	always_comb begin
		next_rdata = 32'h0000_0000;
		next_slverr = 1'b0;
		if (!addr_aligned) begin
			next_slverr = 1'b1;
		end else begin
			case (idx)
				monitor_cfg_pkg::IDX_CONV_CHANNEL_CONTROL: next_rdata[7:0] = conv_ctrl;
				monitor_cfg_pkg::IDX_ATTEN_CONFIG_A: next_rdata[7:0] = {atten_a, 1'b1};
				monitor_cfg_pkg::IDX_ATTEN_CONFIG_B: next_rdata[7:0] = atten_b;
				monitor_cfg_pkg::IDX_FAN_RAMP_CONTROL_A: next_rdata[7:0] = ramp_ctrl;
				monitor_cfg_pkg::IDX_BLOCK_STATUS: begin
					next_rdata[7:0] = ramp_duty[0];
					next_rdata[15:8] = ramp_duty[1];
					next_rdata[monitor_cfg_pkg::STATUS_LOCK_BIT] = lock;
				end
				monitor_cfg_pkg::IDX_BLOCK_CONTROL: begin
					next_rdata[monitor_cfg_pkg::LOCK_BIT] = lock;
				end
				default: next_slverr = 1'b1;
			endcase
		end
	end

	// Read data is loaded with pready so it is stable for the whole answer cycle
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			prdata_out <= 32'h0000_0000;
			pslverr_out <= 1'b0;
		end else if (ce_in) begin
			if (psel_in && penable_in && !pready_out) begin
				prdata_out <= pwrite_in ? 32'h0000_0000 : next_rdata;
				pslverr_out <= next_slverr;
			end else begin
				prdata_out <= 32'h0000_0000;
				pslverr_out <= 1'b0;
			end
		end
	end

	// Lock is only undone by the hardware reset, never by software reset
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			lock <= 1'b0;
		end else if (wr_done && idx == monitor_cfg_pkg::IDX_BLOCK_CONTROL
				&& pwdata_in[monitor_cfg_pkg::LOCK_BIT]) begin
			lock <= 1'b1;
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			conv_ctrl <= monitor_cfg_pkg::RST_CONV_CHANNEL_CONTROL;
		end else if (soft_reset) begin
			conv_ctrl <= monitor_cfg_pkg::RST_CONV_CHANNEL_CONTROL;
		end else if (cfg_wr && idx == monitor_cfg_pkg::IDX_CONV_CHANNEL_CONTROL) begin
			conv_ctrl <= pwdata_in[7:0];
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			atten_a <= monitor_cfg_pkg::RST_ATTEN_CONFIG_A[7:1];
		end else if (soft_reset) begin
			atten_a <= monitor_cfg_pkg::RST_ATTEN_CONFIG_A[7:1];
		end else if (cfg_wr && idx == monitor_cfg_pkg::IDX_ATTEN_CONFIG_A) begin
			atten_a <= pwdata_in[7:1];
		end
	end

	// Attenuator B, reserved bits kept as storage
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			atten_b <= monitor_cfg_pkg::RST_ATTEN_CONFIG_B;
		end else if (soft_reset) begin
			atten_b <= monitor_cfg_pkg::RST_ATTEN_CONFIG_B;
		end else if (cfg_wr && idx == monitor_cfg_pkg::IDX_ATTEN_CONFIG_B) begin
			atten_b <= pwdata_in[7:0];
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			ramp_ctrl <= monitor_cfg_pkg::RST_FAN_RAMP_CONTROL_A;
		end else if (soft_reset) begin
			ramp_ctrl <= monitor_cfg_pkg::RST_FAN_RAMP_CONTROL_A;
		end else if (cfg_wr && idx == monitor_cfg_pkg::IDX_FAN_RAMP_CONTROL_A) begin
			ramp_ctrl <= pwdata_in[7:0];
		end
	end

	// Sequencer sees only assigned codes in mode
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			single_channel_active_out <= 1'b0;
		end else if (ce_in) begin
			single_channel_active_out <= conv_ctrl[monitor_cfg_pkg::SINGLE_MODE_BIT]
				&& (conv_ctrl[monitor_cfg_pkg::CHAN_SEL_MSB:monitor_cfg_pkg::CHAN_SEL_LSB]
				<= monitor_cfg_pkg::CHAN_CODE_LAST);
		end
	end

	assign extra_output_enable_a_out = conv_ctrl[monitor_cfg_pkg::EXTRA_OUT_A_BIT];
	assign extra_output_enable_b_out = conv_ctrl[monitor_cfg_pkg::EXTRA_OUT_B_BIT];
	assign single_channel_mode_out = conv_ctrl[monitor_cfg_pkg::SINGLE_MODE_BIT];
	assign channel_select_out = conv_ctrl[monitor_cfg_pkg::CHAN_SEL_MSB:monitor_cfg_pkg::CHAN_SEL_LSB];
	assign attenuator_cfg_a_out = {atten_a, 1'b1};
	assign attenuator_cfg_b_out = atten_b;
	assign acoustic_enable_a_out = ramp_ctrl[monitor_cfg_pkg::ACOUSTIC_A_BIT];
	assign acoustic_enable_b_out = ramp_ctrl[monitor_cfg_pkg::ACOUSTIC_B_BIT];
	assign config_locked_out = lock;
	assign fan_drive_one_duty_out = ramp_duty[0];
	assign fan_drive_two_duty_out = ramp_duty[1];

	assign ramp_enable = ramp_ctrl[monitor_cfg_pkg::ACOUSTIC_B_BIT:monitor_cfg_pkg::ACOUSTIC_A_BIT];
	assign ramp_rate[0] = ramp_ctrl[monitor_cfg_pkg::RATE_A_LSB +: monitor_cfg_pkg::RATE_WIDTH];
	assign ramp_rate[1] = ramp_ctrl[monitor_cfg_pkg::RATE_B_LSB +: monitor_cfg_pkg::RATE_WIDTH];
	assign ramp_target[0] = fan_drive_one_target_in;
	assign ramp_target[1] = fan_drive_two_target_in;

	for (genvar ch = 0; ch < 2; ch++) begin : g_ramp
		fan_duty_ramp #(
			.SLOT_CYCLES(SLOT_CYCLES)
		) u_ramp (
			.clk_in(clk_in),
			.reset_in(reset_in),
			.ce_in(ce_in),
			.enable_in(ramp_enable[ch]),
			.rate_in(ramp_rate[ch]),
			.target_duty_in(ramp_target[ch]),
			.duty_out(ramp_duty[ch])
		);
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);

	sequence s_cfg_write(logic [5:0] target);
		cfg_wr && !soft_reset && idx == target;
	endsequence

	sequence s_wait_then_ready;
		(psel_in && penable_in && !pready_out && ce_in) ##1 pready_out;
	endsequence

	AST_PREADY_ONE_WAIT: assert property (
		(psel_in && penable_in && !pready_out && ce_in) |-> s_wait_then_ready)
		else $error("pready did not rise after one wait cycle");

	AST_EXTRA_OUT_A: assert property (
		s_cfg_write(monitor_cfg_pkg::IDX_CONV_CHANNEL_CONTROL) |=>
		extra_output_enable_a_out == $past(pwdata_in[0]))
		else $error("Extra output enable A not written");

	AST_EXTRA_OUT_B: assert property (
		s_cfg_write(monitor_cfg_pkg::IDX_CONV_CHANNEL_CONTROL) |=>
		extra_output_enable_b_out == $past(pwdata_in[1]))
		else $error("Extra output enable B not written");

	AST_SINGLE_ACTIVE: assert property (
		(ce_in && single_channel_mode_out
		&& channel_select_out <= monitor_cfg_pkg::CHAN_CODE_LAST)
		|=> single_channel_active_out)
		else $error("Single channel mode not signalled");

	AST_CHANNEL_SELECT: assert property (
		s_cfg_write(monitor_cfg_pkg::IDX_CONV_CHANNEL_CONTROL) |=>
		channel_select_out == $past(pwdata_in[7:3]))
		else $error("Channel select not written");

	AST_ATTEN_A_FIXED: assert property (
		s_cfg_write(monitor_cfg_pkg::IDX_ATTEN_CONFIG_A) |=>
		attenuator_cfg_a_out == {$past(pwdata_in[7:1]), 1'b1})
		else $error("Attenuator A write wrong");

	AST_ATTEN_B_STORE: assert property (
		s_cfg_write(monitor_cfg_pkg::IDX_ATTEN_CONFIG_B) |=>
		attenuator_cfg_b_out == $past(pwdata_in[7:0]))
		else $error("Attenuator B write wrong");

	AST_RAMP_CTRL_STORE: assert property (
		s_cfg_write(monitor_cfg_pkg::IDX_FAN_RAMP_CONTROL_A) |=>
		(acoustic_enable_a_out == $past(pwdata_in[0]))
		&& (acoustic_enable_b_out == $past(pwdata_in[1]))
		&& (ramp_rate[0] == $past(pwdata_in[4:2]))
		&& (ramp_rate[1] == $past(pwdata_in[7:5])))
		else $error("Acoustics control write wrong");

	AST_SOFT_RESET_DEFAULTS: assert property (
		soft_reset |=> (attenuator_cfg_b_out == monitor_cfg_pkg::RST_ATTEN_CONFIG_B)
		&& (attenuator_cfg_a_out == monitor_cfg_pkg::RST_ATTEN_CONFIG_A)
		&& (channel_select_out == monitor_cfg_pkg::RST_CONV_CHANNEL_CONTROL[7:3])
		&& !acoustic_enable_a_out)
		else $error("Software reset did not restore defaults");

	AST_LOCK_BLOCKS_WRITE: assert property (
		(lock && wr_done && idx == monitor_cfg_pkg::IDX_ATTEN_CONFIG_B && !soft_reset)
		|=> $stable(attenuator_cfg_b_out))
		else $error("Write took effect while locked");

	AST_INACTIVE_OUT_OF_MODE: assert property (
		(ce_in && !single_channel_mode_out) |=> !single_channel_active_out)
		else $error("Channel field acted outside single channel mode");

	// Clock enable low must hold every stored setting and both applied duties
	AST_CE_FREEZE: assert property (
		!ce_in |=> $stable({conv_ctrl, atten_a, atten_b, ramp_ctrl, lock, ramp_duty}))
		else $error("State changed while clock enable was low");

	AST_SLVERR_WITH_READY: assert property (
		pslverr_out |-> pready_out)
		else $error("Error response outside the answer cycle");

	AST_READ_DATA_IDLE: assert property (
		!pready_out |-> (prdata_out == 32'h0000_0000))
		else $error("Read data not zero outside the answer cycle");

endmodule // monitor_config_registers

// ===== test_monitor_config_registers.sv
module test_monitor_config_registers;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int SLOT = 4;

	logic clk_in, reset_in, ce_in, psel, penable, pwrite;
	logic [7:0] paddr, tgt_one, tgt_two;
	logic [31:0] pwdata, prdata_out;
	logic pready_out, pslverr_out, ext_a, ext_b, mode, active, ac_a, ac_b, locked;
	logic [4:0] chan;
	logic [7:0] att_a, att_b, duty_one, duty_two;
	logic [31:0] seed, rd, v;
	logic [7:0] sh [4];
	logic [5:0] ridx [4];
	logic [7:0] bad [3];
	logic [7:0] steps [8] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h08, 8'h0C, 8'h18, 8'h30};
	logic er, lk;
	int n_errors, n_compared;

	monitor_config_registers #(.SLOT_CYCLES(SLOT)) dut_u (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.ce_in(ce_in),
		.psel_in(psel),
		.penable_in(penable),
		.pwrite_in(pwrite),
		.paddr_in(paddr),
		.pwdata_in(pwdata),
		.prdata_out(prdata_out),
		.pready_out(pready_out),
		.pslverr_out(pslverr_out),
		.fan_drive_one_target_in(tgt_one),
		.fan_drive_two_target_in(tgt_two),
		.extra_output_enable_a_out(ext_a),
		.extra_output_enable_b_out(ext_b),
		.single_channel_mode_out(mode),
		.channel_select_out(chan),
		.single_channel_active_out(active),
		.attenuator_cfg_a_out(att_a),
		.attenuator_cfg_b_out(att_b),
		.acoustic_enable_a_out(ac_a),
		.acoustic_enable_b_out(ac_b),
		.fan_drive_one_duty_out(duty_one),
		.fan_drive_two_duty_out(duty_two),
		.config_locked_out(locked)
	);

	initial begin
		clk_in = 1'h0;
		forever #12.5 clk_in = ~clk_in;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [7:0] ad(input logic [5:0] idx);
		return {idx, 2'h0};
	endfunction

	// Attenuator A bit 0 is reserved and always reads one
	function automatic logic [7:0] stored(input logic [1:0] r, input logic [7:0] d);
		return (r == 2'h1) ? (d | 8'h01) : d;
	endfunction

	// Either no move or exactly min(step, distance) toward the target t
	function automatic logic okstep(input logic [7:0] p, input logic [7:0] c,
			input logic [7:0] st, input logic [7:0] t);
		logic [7:0] m;
		if (t >= p) begin
			m = (t - p < st) ? t - p : st;
			return (c === p) || (c === p + m);
		end
		m = (p - t < st) ? p - t : st;
		return (c === p) || (c === p - m);
	endfunction

	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One idle cycle after each transfer keeps psel from being driven twice in one step
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_in);
		penable <= 1'h1;
		do begin
			@(posedge clk_in);
			n++;
		end while (pready_out !== 1'h1 && n < 20);
		if (pready_out !== 1'h1) begin
			n_errors++;
			results();
		end
		rd = prdata_out;
		er = pslverr_out;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk_in);
	endtask

	task automatic wr(input logic [1:0] r, input logic [31:0] d);
		apb(1'h1, ad(ridx[r]), d);
		if (!lk) begin
			sh[r] = stored(r, d[7:0]);
		end
	endtask

	task automatic defaults();
		sh = '{8'h00, 8'hFF, 8'h37, 8'h00};
	endtask

	task automatic rdall();
		for (int r = 0; r < 4; r++) begin
			apb(1'h0, ad(ridx[r]), 32'h0000_0000);
			chk(rd, {24'h00_0000, sh[r]});
			chk(er, 1'h0);
		end
	endtask

	// The active flag lags the register by one cycle, hence two edges
	task automatic outs();
		repeat (2) @(posedge clk_in);
		chk(ext_a, sh[0][0]);
		chk(ext_b, sh[0][1]);
		chk(mode, sh[0][2]);
		chk(chan, sh[0][7:3]);
		chk(active, sh[0][2] && sh[0][7:3] <= monitor_cfg_pkg::CHAN_CODE_LAST);
		chk(att_a, sh[1]);
		chk(att_b, sh[2]);
		chk(ac_a, sh[3][0]);
		chk(ac_b, sh[3][1]);
	endtask

	// Follows both duties each cycle until they reach their targets
	task automatic track(input logic [7:0] t1, input logic [7:0] t2, input logic [7:0] st,
			output int n);
		logic [7:0] p1, p2;
		n = 0;
		p1 = duty_one;
		p2 = duty_two;
		while ((duty_one !== t1 || duty_two !== t2) && n < 3000) begin
			@(posedge clk_in);
			n++;
			chk(okstep(p1, duty_one, st, t1), 1'h1);
			chk(okstep(p2, duty_two, st, t2), 1'h1);
			p1 = duty_one;
			p2 = duty_two;
		end
		if (n >= 3000) begin
			n_errors++;
			results();
		end
	endtask

	task automatic ramp(input logic [2:0] c);
		int n, ns;
		logic [7:0] st;
		st = steps[c];
		ns = (255 + int'(st) - 1) / int'(st);
		v = rnd();
		tgt_one <= v[7:0];
		tgt_two <= v[15:8];
		wr(2'h3, 32'h0000_0000);
		repeat (3) @(posedge clk_in);
		chk(duty_one, v[7:0]);
		chk(duty_two, v[15:8]);
		// Clock enable low must freeze the applied duty
		ce_in <= 1'h0;
		tgt_one <= 8'h00;
		tgt_two <= 8'h00;
		repeat (3) @(posedge clk_in);
		chk(duty_one, v[7:0]);
		ce_in <= 1'h1;
		repeat (3) @(posedge clk_in);
		chk(duty_two, 8'h00);
		wr(2'h3, {24'h00_0000, c, c, 2'h3});
		tgt_one <= 8'hFF;
		tgt_two <= 8'hFF;
		track(8'hFF, 8'hFF, st, n);
		chk(n >= (ns - 1) * SLOT && n <= ns * SLOT + SLOT, 1'h1);
		// Downward ramp to the random targets
		tgt_one <= v[7:0];
		tgt_two <= v[15:8];
		track(v[7:0], v[15:8], st, n);
		chk(n <= ns * SLOT + SLOT, 1'h1);
	endtask

	initial begin
		seed = 32'h0000_003B;
		n_errors = 0;
		n_compared = 0;
		lk = 1'h0;
		reset_in = 1'h1;
		ce_in = 1'h1;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		tgt_one = 8'h00;
		tgt_two = 8'h00;
		ridx = '{monitor_cfg_pkg::IDX_CONV_CHANNEL_CONTROL, monitor_cfg_pkg::IDX_ATTEN_CONFIG_A,
			monitor_cfg_pkg::IDX_ATTEN_CONFIG_B, monitor_cfg_pkg::IDX_FAN_RAMP_CONTROL_A};
		bad = '{8'h00, 8'h59, 8'h6C};
		defaults();
		repeat (2) @(posedge clk_in);
		reset_in <= 1'h0;
		rdall();
		outs();
		wr(2'h1, 32'h0000_0000);
		wr(2'h2, 32'hFFFF_FFC8);
		wr(2'h0, 32'h0000_008C);
		rdall();
		outs();
		wr(2'h0, 32'h0000_0094);
		outs();
		wr(2'h0, 32'h0000_0089);
		outs();
		for (int i = 0; i < 24; i++) begin
			v = rnd();
			wr(v[1:0], rnd());
			tgt_one <= v[15:8];
			tgt_two <= v[23:16];
			outs();
		end
		rdall();
		for (int c = 0; c < 8; c++) begin
			ramp(3'(c));
		end
		foreach (bad[k]) begin
			apb(1'h1, bad[k], 32'hFFFF_FFFF);
			chk(er, 1'h1);
			apb(1'h0, bad[k], 32'h0000_0000);
			chk(er, 1'h1);
			chk(rd, 32'h0000_0000);
		end
		rdall();
		wr(2'h0, 32'h0000_0055);
		apb(1'h1, ad(monitor_cfg_pkg::IDX_BLOCK_CONTROL), 32'h0000_0001);
		defaults();
		rdall();
		outs();
		wr(2'h0, 32'h0000_0055);
		apb(1'h1, ad(monitor_cfg_pkg::IDX_BLOCK_CONTROL), 32'h0000_0002);
		lk = 1'h1;
		wr(2'h0, 32'h0000_00AA);
		wr(2'h2, 32'h0000_0000);
		rdall();
		outs();
		chk(locked, 1'h1);
		apb(1'h0, ad(monitor_cfg_pkg::IDX_BLOCK_STATUS), 32'h0000_0000);
		chk(rd[monitor_cfg_pkg::STATUS_LOCK_BIT], 1'h1);
		// Acoustics are off after the software reset, so duty equals target
		chk(rd[15:0], {tgt_two, tgt_one});
		apb(1'h1, ad(monitor_cfg_pkg::IDX_BLOCK_CONTROL), 32'h0000_0001);
		defaults();
		rdall();
		chk(locked, 1'h1);
		// Only the reset pin releases the lock
		reset_in <= 1'h1;
		repeat (2) @(posedge clk_in);
		reset_in <= 1'h0;
		@(posedge clk_in);
		lk = 1'h0;
		chk(locked, 1'h0);
		wr(2'h0, 32'h0000_00AA);
		rdall();
		outs();
		results();
	end
endmodule // test_monitor_config_registers
